/* File: atpw_pkg.sv */
// Constants and carrier types for the asynchronous timer block.
// Assumes a 32-bit APB master and a single 20 MHz system clock.
package atpw_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned APB_AW = 12;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL_A = 10'h0b0;
  localparam logic [9:0] IDX_CTRL_B = 10'h0b1;
  localparam logic [9:0] IDX_COUNT = 10'h0b2;
  localparam logic [9:0] IDX_CMP_A = 10'h0b3;
  localparam logic [9:0] IDX_CMP_B = 10'h0b4;
  localparam logic [9:0] IDX_ASYNC_STATUS = 10'h0b6;
  localparam logic [9:0] IDX_GEN_CTRL = 10'h0b7;

  // Field positions
  localparam int unsigned COM_A_LSB = 6;
  localparam int unsigned COM_B_LSB = 4;
  localparam int unsigned FORCE_A_BIT = 7;
  localparam int unsigned FORCE_B_BIT = 6;
  localparam int unsigned MODE_MSB_BIT = 3;
  localparam int unsigned ASYNC_SEL_BIT = 5;
  localparam int unsigned PSR_BIT = 1;

  // Reset values and masks
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] CTRL_A_WMASK = 8'hf3;
  localparam logic [7:0] CTRL_B_WMASK = 8'h0f;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;

  // Waveform modes
  localparam logic [2:0] WM_NORMAL = 3'h0;
  localparam logic [2:0] WM_PC_FF = 3'h1;
  localparam logic [2:0] WM_CTC = 3'h2;
  localparam logic [2:0] WM_FAST_FF = 3'h3;
  localparam logic [2:0] WM_PC_CMP = 3'h5;
  localparam logic [2:0] WM_FAST_CMP = 3'h7;

  // Clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV32 = 3'h3;
  localparam logic [2:0] CS_DIV64 = 3'h4;
  localparam logic [2:0] CS_DIV128 = 3'h5;
  localparam logic [2:0] CS_DIV256 = 3'h6;
  localparam logic [2:0] CS_DIV1024 = 3'h7;
  localparam int unsigned PRESC_W = 10;

  typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} atpw_dir_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
  } atpw_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } atpw_apb_rsp_t;

endpackage

/* File: atpw_prescaler.sv */
// Resettable prescaler producing one-cycle timer ticks from source ticks.
// Assumes src_tick is a one-cycle pulse in the clk domain.
`timescale 1ns/1ps
module atpw_prescaler
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic src_tick,
  input wire logic clr,
  input wire logic [2:0] sel,
  output logic tick_q
);
  import atpw_pkg::*;

  typedef struct packed {
    logic [PRESC_W-1:0] cnt;
    logic tick;
  } atpw_presc_state_t;

  atpw_presc_state_t s_q;
  atpw_presc_state_t s_d;

  function automatic logic [PRESC_W-1:0] tap_mask(input logic [2:0] cs);
    logic [PRESC_W-1:0] m;
    m = '0;
    unique case (cs)
      CS_STOP, CS_DIV1: m = 10'h000;
      CS_DIV8: m = 10'h007;
      CS_DIV32: m = 10'h01f;
      CS_DIV64: m = 10'h03f;
      CS_DIV128: m = 10'h07f;
      CS_DIV256: m = 10'h0ff;
      CS_DIV1024: m = 10'h3ff;
    endcase
    return m;
  endfunction

  always_comb
  begin
    s_d = s_q;
    if (clr)
    begin
      s_d.cnt = '0;
    end
    else if (src_tick)
    begin
      s_d.cnt = s_q.cnt + 10'h001;
    end
    if (sel == CS_STOP)
    begin
      s_d.tick = 1'b0;
    end
    else
    begin
      s_d.tick = src_tick && !clr && ((s_q.cnt & tap_mask(sel)) == tap_mask(sel));
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign tick_q = s_q.tick;

endmodule

/* File: atpw_timer.sv */
// Timer clock select, prescaler control, waveform modes and compare outputs.
// Assumes an APB master on clk; pin inputs other than osc_in_pin share clk.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - Timer source defaults to system clock; async select bit picks oscillator pin.
// - With async selected, oscillator pins leave their port function.
// - Prescaler offers undivided, stop and divide by 8,32,64,128,256,1024.
// - Writing the prescaler-reset bit restarts the prescaler phase.
// - Nonzero channel A mode drives pin, enabled only by its direction bit.
// - Non-PWM channel A: 0 off, 1 toggle, 2 clear, 3 set on match.
// - Fast PWM A: 1 toggles if mode MSB, 2 non-inverting, 3 inverting.
// - Fast PWM A with compare at top: match ignored, action at bottom.
// - Phase-correct A: 2 clear up/set down, 3 opposite, 1 toggles if MSB.
// - Phase-correct with compare at top: match ignored, action at top.
// - Nonzero channel B mode drives pin, gated by its direction bit.
// - Non-PWM channel B: 0 off, 1 toggle, 2 clear, 3 set on match.
// - Fast PWM B: 1 reserved, 2 non-inverting, 3 inverting.
// - Fast PWM B with compare at top: match ignored, action at bottom.
// - Phase-correct B: 1 reserved, 2 clear up/set down, 3 opposite.
// - Mode is control B bit 3 over control A bits 1:0; 4,6 reserved.
// - Normal top 0xFF, CTC top compare A; immediate update; overflow at max.
// - Phase-correct updates at top, overflow at bottom; fast updates at bottom.
// - Clock select: 0 stop, 1 undivided, 2..7 divided taps.
// - Force strobes act in non-PWM only, no counter clear, read zero.
module atpw_timer
(
  input wire logic clk,
  input wire logic rstn,
  input atpw_pkg::atpw_apb_req_t apb_req,
  output atpw_pkg::atpw_apb_rsp_t apb_rsp,
  input wire logic osc_in_pin,
  input wire logic chan_a_dir,
  input wire logic chan_b_dir,
  output logic osc_pins_detach,
  output logic chan_a_wave_out,
  output logic chan_a_oe_n,
  output logic chan_b_wave_out,
  output logic chan_b_oe_n,
  output logic overflow_flag
);
  import atpw_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] cnt;
    logic [7:0] cmp_a_buf;
    logic [7:0] cmp_b_buf;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic async_sel;
    logic psr;
    logic [2:0] osc_sync;
    logic osc_lvl;
    atpw_dir_t dir;
    logic wave_a;
    logic wave_b;
    logic oe_a_n;
    logic oe_b_n;
    logic ovf;
    atpw_apb_rsp_t rsp;
  } atpw_state_t;

  atpw_state_t s_q;
  atpw_state_t s_d;
  logic tick;
  logic src_tick;
  logic [2:0] mode;
  logic [7:0] top;
  logic setup;
  logic wr;
  logic [10:0] hit;
  logic force_a;
  logic force_b;
  logic cnt_wr;

  // Index plus valid bit; misaligned or unknown addresses miss
  function automatic logic [10:0] reg_hit(input logic [APB_AW-1:0] a);
    logic ok;
    ok = (a[1:0] == 2'b00);
    unique case (a[APB_AW-1:2])
      IDX_CTRL_A, IDX_CTRL_B, IDX_COUNT, IDX_CMP_A, IDX_CMP_B, IDX_ASYNC_STATUS,
      IDX_GEN_CTRL: return {ok, a[APB_AW-1:2]};
      default: return {1'b0, a[APB_AW-1:2]};
    endcase
  endfunction

  function automatic logic is_pc(input logic [2:0] m);
    return (m == WM_PC_FF) || (m == WM_PC_CMP);
  endfunction

  function automatic logic is_fast(input logic [2:0] m);
    return (m == WM_FAST_FF) || (m == WM_FAST_CMP);
  endfunction

  // Next compare output level for one channel
  function automatic logic wave_next(input logic cur, input logic [1:0] com,
    input logic [2:0] m, input logic match, input atpw_dir_t d, input logic edge_ev,
    input logic special, input logic is_a);
    logic r;
    r = cur;
    if (m == WM_NORMAL || m == WM_CTC)
    begin
      if (match && com != 2'b00)
      begin
        r = (com == 2'b01) ? !cur : com[0];
      end
    end
    else if (is_fast(m) || is_pc(m))
    begin
      if (com == 2'b01)
      begin
        r = (is_a && m[2] && match) ? !cur : cur;
      end
      else if (com[1] && special)
      begin
        r = edge_ev ? !com[0] : cur;
      end
      else if (com[1] && is_fast(m))
      begin
        r = match ? com[0] : (edge_ev ? !com[0] : cur);
      end
      else if (com[1] && match)
      begin
        r = (d == DIR_UP) ? com[0] : !com[0];
      end
    end
    return r;
  endfunction

  atpw_prescaler u_presc
  (
    .clk(clk),
    .rstn(rstn),
    .src_tick(src_tick),
    .clr(s_q.psr),
    .sel(s_q.ctrl_b[2:0]),
    .tick_q(tick)
  );

  assign src_tick = s_q.async_sel ? (s_q.osc_sync[1] && s_q.osc_sync[2] && !s_q.osc_lvl)
    : 1'b1;
  assign mode = {s_q.ctrl_b[MODE_MSB_BIT], s_q.ctrl_a[1:0]};
  assign top = (mode == WM_CTC || mode[2]) ? s_q.cmp_a : CNT_MAX;
  assign setup = apb_req.psel && !apb_req.penable;
  assign wr = apb_req.psel && apb_req.penable && s_q.rsp.pready && apb_req.pwrite;
  assign hit = reg_hit(apb_req.paddr);
  assign cnt_wr = wr && hit[10] && hit[9:0] == IDX_COUNT;
  assign force_a = wr && hit[10] && hit[9:0] == IDX_CTRL_B && apb_req.pwdata[FORCE_A_BIT]
    && (mode == WM_NORMAL || mode == WM_CTC);
  assign force_b = wr && hit[10] && hit[9:0] == IDX_CTRL_B && apb_req.pwdata[FORCE_B_BIT]
    && (mode == WM_NORMAL || mode == WM_CTC);

  always_comb
  begin
    logic at_top;
    logic match_a;
    logic match_b;
    logic edge_ev;
    at_top = 1'b0;
    match_a = 1'b0;
    match_b = 1'b0;
    edge_ev = 1'b0;
    s_d = s_q;
    s_d.osc_sync = {s_q.osc_sync[1:0], osc_in_pin};
    // Level only moves once the last two stages agree
    if (s_q.osc_sync[1] == s_q.osc_sync[2])
    begin
      s_d.osc_lvl = s_q.osc_sync[2];
    end
    s_d.psr = 1'b0;
    s_d.ovf = 1'b0;
    at_top = (s_q.cnt == top);
    edge_ev = tick && at_top && (is_fast(mode) || s_q.dir == DIR_UP);
    // forced match counts with a real one, raises no overflow
    match_a = (tick && s_q.cnt == s_q.cmp_a && !(is_fast(mode) && s_q.cmp_a == top
      && s_q.ctrl_a[7])) || force_a;
    match_b = (tick && s_q.cnt == s_q.cmp_b && !(is_fast(mode) && s_q.cmp_b == top
      && s_q.ctrl_a[5])) || force_b;
    if (is_pc(mode))
    begin
      match_a = match_a && !(s_q.cmp_a == top && s_q.ctrl_a[7]);
      match_b = match_b && !(s_q.cmp_b == top && s_q.ctrl_a[5]);
    end
    s_d.wave_a = wave_next(s_q.wave_a, s_q.ctrl_a[7:6], mode, match_a, s_q.dir, edge_ev,
      s_q.cmp_a == top && s_q.ctrl_a[7], 1'b1);
    s_d.wave_b = wave_next(s_q.wave_b, s_q.ctrl_a[5:4], mode, match_b, s_q.dir, edge_ev,
      s_q.cmp_b == top && s_q.ctrl_a[5], 1'b0);
    s_d.oe_a_n = !((s_q.ctrl_a[7:6] != 2'b00) && chan_a_dir);
    s_d.oe_b_n = !((s_q.ctrl_a[5:4] != 2'b00) && chan_b_dir);
    if (tick)
    begin
      unique case (mode)
        WM_NORMAL:
        begin
          s_d.cnt = s_q.cnt + 8'h01;
          s_d.ovf = (s_q.cnt == CNT_MAX);
        end
        WM_CTC, WM_FAST_FF, WM_FAST_CMP:
        begin
          s_d.cnt = at_top ? CNT_BOTTOM : s_q.cnt + 8'h01;
          s_d.ovf = (mode == WM_FAST_CMP) ? at_top : (s_q.cnt == CNT_MAX);
        end
        WM_PC_FF, WM_PC_CMP:
        begin
          if (s_q.dir == DIR_UP)
          begin
            s_d.dir = at_top ? DIR_DOWN : DIR_UP;
            s_d.cnt = at_top ? s_q.cnt - 8'h01 : s_q.cnt + 8'h01;
          end
          else
          begin
            s_d.dir = (s_q.cnt == CNT_BOTTOM) ? DIR_UP : DIR_DOWN;
            s_d.cnt = (s_q.cnt == CNT_BOTTOM) ? s_q.cnt + 8'h01 : s_q.cnt - 8'h01;
            s_d.ovf = (s_q.cnt == CNT_BOTTOM);
          end
        end
        // Reserved modes hold the counter
        default: s_d.cnt = s_q.cnt;
      endcase
    end
    if (mode == WM_NORMAL || mode == WM_CTC || (tick && at_top && (is_fast(mode)
      || (is_pc(mode) && s_q.dir == DIR_UP))))
    begin
      s_d.cmp_a = s_q.cmp_a_buf;
      s_d.cmp_b = s_q.cmp_b_buf;
    end
    if (!is_pc(mode))
    begin
      s_d.dir = DIR_UP;
    end
    // APB: answer ready in the first access cycle
    s_d.rsp.pready = setup;
    s_d.rsp.pslverr = setup && !hit[10];
    s_d.rsp.prdata = '0;
    if (setup && hit[10])
    begin
      unique case (hit[9:0])
        IDX_CTRL_A: s_d.rsp.prdata[7:0] = s_q.ctrl_a;
        IDX_CTRL_B: s_d.rsp.prdata[7:0] = s_q.ctrl_b;
        IDX_COUNT: s_d.rsp.prdata[7:0] = s_q.cnt;
        IDX_CMP_A: s_d.rsp.prdata[7:0] = s_q.cmp_a_buf;
        IDX_CMP_B: s_d.rsp.prdata[7:0] = s_q.cmp_b_buf;
        IDX_ASYNC_STATUS: s_d.rsp.prdata[ASYNC_SEL_BIT] = s_q.async_sel;
        default: s_d.rsp.prdata = '0;
      endcase
    end
    if (wr && hit[10])
    begin
      unique case (hit[9:0])
        IDX_CTRL_A: s_d.ctrl_a = apb_req.pwdata[7:0] & CTRL_A_WMASK;
        IDX_CTRL_B: s_d.ctrl_b = apb_req.pwdata[7:0] & CTRL_B_WMASK;
        IDX_COUNT: s_d.cnt = apb_req.pwdata[7:0];
        IDX_CMP_A: s_d.cmp_a_buf = apb_req.pwdata[7:0];
        IDX_CMP_B: s_d.cmp_b_buf = apb_req.pwdata[7:0];
        IDX_ASYNC_STATUS: s_d.async_sel = apb_req.pwdata[ASYNC_SEL_BIT];
        IDX_GEN_CTRL: s_d.psr = apb_req.pwdata[PSR_BIT];
        default: s_d.psr = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s_q <= '0;
      s_q.ctrl_a <= CTRL_A_RST;
      s_q.ctrl_b <= CTRL_B_RST;
      s_q.oe_a_n <= 1'b1;
      s_q.oe_b_n <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign apb_rsp = s_q.rsp;
  assign osc_pins_detach = s_q.async_sel;
  assign chan_a_wave_out = s_q.wave_a;
  assign chan_a_oe_n = s_q.oe_a_n;
  assign chan_b_wave_out = s_q.wave_b;
  assign chan_b_oe_n = s_q.oe_b_n;
  assign overflow_flag = s_q.ovf;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_psr_write;
    wr && hit[10] && hit[9:0] == IDX_GEN_CTRL && apb_req.pwdata[PSR_BIT];
  endsequence
  sequence s_strobe_then_low;
    s_q.psr ##1 !s_q.psr;
  endsequence
  property p_psr_pulse;
    s_psr_write |=> s_strobe_then_low;
  endproperty
  a_psr_pulse: assert property (p_psr_pulse) else $error("prescaler reset not a pulse");
  property p_stop;
    $past(s_q.ctrl_b[2:0]) == CS_STOP |-> !tick;
  endproperty
  a_stop: assert property (p_stop) else $error("tick while stopped");
  property p_div1;
    $past(s_q.ctrl_b[2:0]) == CS_DIV1 && !$past(s_q.psr) |-> tick == $past(src_tick);
  endproperty
  a_div1: assert property (p_div1) else $error("undivided tick mismatch");
  property p_force_zero;
    setup && hit[10] && hit[9:0] == IDX_CTRL_B |=> s_q.rsp.prdata[7:6] == 2'b00;
  endproperty
  a_force_zero: assert property (p_force_zero) else $error("strobe bits read one");
  property p_detach;
    wr && hit[10] && hit[9:0] == IDX_ASYNC_STATUS
      |=> osc_pins_detach == $past(apb_req.pwdata[ASYNC_SEL_BIT]);
  endproperty
  a_detach: assert property (p_detach) else $error("pins not detached");
  property p_oe_a;
    s_q.ctrl_a[7:6] != 2'b00 && chan_a_dir |=> !chan_a_oe_n;
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("channel A driver off");
  property p_oe_b;
    s_q.ctrl_a[5:4] == 2'b00 |=> chan_b_oe_n;
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("channel B driving when off");
  property p_toggle;
    mode == WM_NORMAL && s_q.ctrl_a[7:6] == 2'b01 && tick && s_q.cnt == s_q.cmp_a
      |=> chan_a_wave_out != $past(chan_a_wave_out);
  endproperty
  a_toggle: assert property (p_toggle) else $error("channel A did not toggle");
  property p_ctc_wrap;
    mode == WM_CTC && tick && s_q.cnt == s_q.cmp_a && !cnt_wr |=> s_q.cnt == CNT_BOTTOM;
  endproperty
  a_ctc_wrap: assert property (p_ctc_wrap) else $error("CTC did not clear");
  property p_fast_set;
    mode == WM_FAST_FF && s_q.ctrl_a[5:4] == 2'b10 && tick && s_q.cnt == CNT_MAX
      && s_q.cmp_b != CNT_MAX |=> chan_b_wave_out;
  endproperty
  a_fast_set: assert property (p_fast_set) else $error("channel B not set at bottom");
  property p_pc_turn;
    is_pc(mode) && tick && s_q.dir == DIR_UP && s_q.cnt == top && !cnt_wr
      |=> s_q.dir == DIR_DOWN ##1 s_q.dir == DIR_DOWN || tick;
  endproperty
  a_pc_turn: assert property (p_pc_turn) else $error("no turn at top");

endmodule

/* File: async_timer_prescaler_waveform_ctrl_bench.sv */
// Self-checking bench for the asynchronous timer block.
// Assumes atpw_pkg and atpw_timer are compiled first; bench drives APB and pins.
`timescale 1ns/1ps
module async_timer_prescaler_waveform_ctrl_bench;
  import atpw_pkg::*;
  localparam logic [11:0] A_CA = {IDX_CTRL_A, 2'b00};
  localparam logic [11:0] A_CB = {IDX_CTRL_B, 2'b00};
  localparam logic [11:0] A_CNT = {IDX_COUNT, 2'b00};
  localparam logic [11:0] A_OA = {IDX_CMP_A, 2'b00};
  localparam logic [11:0] A_OB = {IDX_CMP_B, 2'b00};
  localparam logic [11:0] A_AS = {IDX_ASYNC_STATUS, 2'b00};
  localparam logic [11:0] A_GC = {IDX_GEN_CTRL, 2'b00};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  atpw_apb_req_t req = '0;
  atpw_apb_rsp_t rsp;
  logic osc_in_pin = 1'b0;
  logic osc_run = 1'b0;
  logic [2:0] osc_cnt = 3'h0;
  logic a_dir = 1'b0;
  logic b_dir = 1'b0;
  logic detach, a_out, a_oe_n, b_out, b_oe_n, ovf;
  logic [31:0] rd;
  logic err;
  logic [7:0] com = 8'h00;
  int fails = 0;
  int cmp_count = 0;
  int iv [8] = '{256, 510, 0, 256, 0, 6, 0, 4};
  int dv [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  logic [1:0] fc [6] = '{2'h1, 2'h1, 2'h3, 2'h2, 2'h3, 2'h0};
  logic fe [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  int dl [3] = '{0, 17, 40};

  atpw_timer dut_u
  (
    .clk(clk),
    .rstn(rstn),
    .apb_req(req),
    .apb_rsp(rsp),
    .osc_in_pin(osc_in_pin),
    .chan_a_dir(a_dir),
    .chan_b_dir(b_dir),
    .osc_pins_detach(detach),
    .chan_a_wave_out(a_out),
    .chan_a_oe_n(a_oe_n),
    .chan_b_wave_out(b_out),
    .chan_b_oe_n(b_oe_n),
    .overflow_flag(ovf)
  );

  always #25 clk = ~clk;

  // Pin toggles every five clocks, so one rising edge per ten clocks
  always @(posedge clk)
  begin
    if (osc_run)
    begin
      osc_cnt <= (osc_cnt == 3'h4) ? 3'h0 : osc_cnt + 3'h1;
      if (osc_cnt == 3'h4)
        osc_in_pin <= ~osc_in_pin;
    end
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      fails++;
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= wd;
    @(posedge clk);
    req.penable <= 1'b1;
    // Values read right at the edge are the ones the slave sampled there
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 20);
    check("pready", rsp.pready, 1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask

  task automatic settle;
    repeat (2) @(negedge clk);
  endtask

  // Stop the clock before changing mode so the counter restarts from zero
  task automatic setm(input logic [2:0] m, input logic [2:0] cs);
    wr(A_CB, {28'h0, m[2], 3'b000});
    wr(A_CA, {24'h0, com[7:4], 2'b00, m[1:0]});
    wr(A_CNT, 32'h0);
    wr(A_CB, {28'h0, m[2], cs});
  endtask

  task automatic wait_ovf(input int lim, output int n);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (ovf !== 1'b1 && n < lim);
  endtask

  task automatic meas(input int exp);
    int n;
    n = 0;
    if (exp == 0)
    begin
      repeat (600)
      begin
        @(negedge clk);
        if (ovf !== 1'b0)
          n++;
      end
      check("no overflow", n, 0);
    end
    else
    begin
      wait_ovf(2 * exp + 20, n);
      wait_ovf(2 * exp + 20, n);
      check("overflow interval", n, exp);
    end
  endtask

  initial
  begin
    repeat (80000) @(posedge clk);
    fails++;
    print_verdict;
  end

  initial
  begin
    int n [3];
    int hi [2];
    int tg;
    logic prev;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check("oe_n a rst", a_oe_n, 1);
    check("oe_n b rst", b_oe_n, 1);
    check("detach rst", detach, 0);
    rdc("ctrl_a rst", A_CA, 0);
    rdc("ctrl_b rst", A_CB, 0);
    wr(A_CA, 32'hff);
    rdc("ctrl_a mask", A_CA, 32'hf3);
    wr(A_CA, 32'h0);
    wr(A_CB, 32'h38);
    rdc("ctrl_b mask", A_CB, 32'h08);
    wr(A_GC, 32'h02);
    rdc("psr reads 0", A_GC, 0);
    apb(1'b0, 12'h2d4, 32'h0);
    check("unmapped err", err, 1);
    check("unmapped data", rd, 0);
    apb(1'b1, 12'h2c1, 32'hff);
    check("misaligned err", err, 1);
    rdc("write ignored", A_CA, 0);
    setm(3'h2, 3'h0);
    wr(A_CNT, 32'h05);
    for (int i = 0; i < 6; i++)
    begin
      wr(A_CA, {24'h0, fc[i], fc[i], 4'h2});
      wr(A_CB, 32'hc0);
      settle;
      check("force a", a_out, fe[i]);
      check("force b", b_out, fe[i]);
    end
    rdc("count kept", A_CNT, 32'h05);
    rdc("force reads 0", A_CB, 0);
    wr(A_CA, 32'ha3);
    wr(A_CB, 32'hc0);
    settle;
    check("force pwm a", a_out, 1);
    @(posedge clk);
    a_dir <= 1'b1;
    b_dir <= 1'b1;
    wr(A_CA, 32'h40);
    settle;
    check("oe a on", a_oe_n, 0);
    check("oe b off", b_oe_n, 1);
    wr(A_CA, 32'h10);
    settle;
    check("oe a off", a_oe_n, 1);
    check("oe b on", b_oe_n, 0);
    @(posedge clk);
    b_dir <= 1'b0;
    settle;
    check("oe b dir", b_oe_n, 1);
    com = 8'h00;
    setm(3'h0, 3'h0);
    wr(A_OA, 32'h03);
    for (int m = 0; m < 8; m++)
    begin
      setm(3'(m), 3'h1);
      meas(iv[m]);
    end
    for (int c = 2; c < 8; c++)
    begin
      setm(3'h7, 3'(c));
      meas(4 * dv[c]);
    end
    setm(3'h7, 3'h0);
    meas(0);
    wr(A_AS, 32'h20);
    osc_run <= 1'b1;
    settle;
    check("pins detached", detach, 1);
    setm(3'h7, 3'h1);
    meas(40);
    wr(A_AS, 32'h0);
    settle;
    check("pins attached", detach, 0);
    setm(3'h7, 3'h4);
    // Varied delays expose a prescaler phase that survives the reset
    for (int i = 0; i < 3; i++)
    begin
      repeat (dl[i]) @(posedge clk);
      wr(A_GC, 32'h02);
      wr(A_CNT, 32'h0);
      wait_ovf(400, n[i]);
      check("phase after reset", n[i], n[0]);
    end
    setm(3'h0, 3'h0);
    wr(A_OA, 32'h07);
    wr(A_OB, 32'h01);
    for (int k = 0; k < 2; k++)
    begin
      for (int c = 0; c < 2; c++)
      begin
        com = {2'b01, 1'b1, c[0], 4'h0};
        setm(k ? 3'h5 : 3'h7, 3'h1);
        wait_ovf(100, tg);
        hi[c] = 0;
        tg = 0;
        prev = a_out;
        repeat (k ? 56 : 32)
        begin
          @(negedge clk);
          hi[c] += (b_out === 1'b1);
          tg += (a_out !== prev);
          prev = a_out;
        end
        check("toggle count a", tg, 4);
      end
      check("duty sum b", hi[0] + hi[1], k ? 56 : 32);
      check("duty low b", hi[0] < (k ? 28 : 16), 1);
    end
    // Compare at top with clear mode: a naive match would pull the pins low
    wr(A_OB, 32'h07);
    com = 8'ha0;
    for (int k = 0; k < 2; k++)
    begin
      setm(k ? 3'h5 : 3'h7, 3'h1);
      wait_ovf(100, tg);
      tg = 0;
      repeat (32)
      begin
        @(negedge clk);
        tg += (a_out !== 1'b1) + (b_out !== 1'b1);
      end
      check("top compare held", tg, 0);
    end
    print_verdict;
  end
endmodule
